// ---- rtl/icoc_capture_compare.sv ----
// capture channel, compare channel and their apb register file
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/10ps
// Operation
// - each qualifying capture event latches the full 16-bit selected timer
// - capture source is time base a or b, per the timer select bit
// - mode field picks every/falling/rising/4th/16th rising edge; 110 disables
// - mode 111 makes the pin a rising-edge interrupt and wake source only
// - capture pin events wake the cpu from sleep, or from idle unless idle-stop is set in a storing mode
// - captured values go through a four-word fifo
// - interrupt after every 1, 2, 3 or 4 captures per the field
// - overflow flag is read-only, set and cleared by hardware
// - compare timer select set picks time base b, clear picks a
// - compare timer against one or two values, change output on equality
// - compare mode 000 disables, pin follows general-purpose port logic
// - mode 001 starts low, match drives high, interrupt on that rise
// - mode 010 starts high, match drives low, interrupt on that fall
// - mode 011 keeps level, toggles on match, interrupt on both edges
// - mode 100 starts low, single pulse, interrupt on ending fall
// - mode 101 starts low, repeating pulses, interrupt on each fall
// - mode 110 pwm without fault; starts by primary value zero-ness; no interrupt
// - mode 111 pwm with fault; falling fault input raises interrupt
// - pwm fault flag set on fault in 111, cleared by hardware only
// - compare idle-stop set halts the channel while the cpu idles
module icoc_capture_compare #(
  parameter int DEPTH = 4
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] timeBaseA,
  input  wire logic [15:0] timeBaseB,
  input  wire logic        cpuIdle,
  input  wire logic        cpuSleep,
  input  wire logic        capturePin,
  input  wire logic        faultPinA,
  input  wire logic        gpioPortOut,
  output logic             comparePin,
  output logic             captureIrq,
  output logic             compareIrq,
  output logic             wakeRequest
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [15:0] VAL0 = icoc_pkg::VAL_RESET;
  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("DEPTH must be a power of two, at least 2");
    end
  endgenerate
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [DEPTH-1:0][15:0] fifo;
    logic [AW-1:0]          wrPtr;
    logic [AW-1:0]          rdPtr;
    logic [AW:0]            count;
    logic                   capIdle;
    logic                   capTsel;
    logic [1:0]             capIci;
    logic                   capOv;
    logic [2:0]             capMode;
    logic [2:0]             capModePrev;
    logic [1:0]             capIntCnt;
    logic [3:0]             prescale;
    logic                   capSync1;
    logic                   capSync2;
    logic                   capPrev;
    logic                   fltSync1;
    logic                   fltSync2;
    logic                   fltPrev;
    logic                   cmpIdle;
    logic                   cmpTsel;
    logic                   cmpFlt;
    logic [2:0]             cmpMode;
    logic [2:0]             cmpModePrev;
    logic                   cmpOut;
    logic                   cmpDone;
    logic [15:0]            cmpPri;
    logic [15:0]            cmpSec;
    logic                   pin;
    logic                   capIrq;
    logic                   cmpIrq;
    logic                   wake;
    logic [31:0]            prdata;
  } icoc_state_s;
  icoc_state_s st_reg;
  icoc_state_s st_next;
  logic        capEvt;
  logic        capPush;
  logic        capPop;
  logic        capFull;
  logic        mPri;
  logic        mSec;
  logic        cmpHalt;
  function automatic logic addrMapped(input logic [7:0] a);
    addrMapped = (a == icoc_pkg::OFS_CAP_CTL) || (a == icoc_pkg::OFS_CAP_BUF) ||
                 (a == icoc_pkg::OFS_CMP_CTL) || (a == icoc_pkg::OFS_CMP_PRI) ||
                 (a == icoc_pkg::OFS_CMP_SEC);
  endfunction
  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic        rise;
    logic        fall;
    logic        fFall;
    logic        rawEvt;
    logic        storeMode;
    logic [15:0] capTimer;
    logic [15:0] cmpTimer;
    logic        access;
    logic [15:0] rd16;
    rise      = st_reg.capSync2 & ~st_reg.capPrev;
    fall      = ~st_reg.capSync2 & st_reg.capPrev;
    fFall     = ~st_reg.fltSync2 & st_reg.fltPrev;
    rawEvt    = 1'b0;
    storeMode = (st_reg.capMode != icoc_pkg::CAP_OFF0) && (st_reg.capMode != icoc_pkg::CAP_OFF) &&
                (st_reg.capMode != icoc_pkg::CAP_INT_ONLY);
    capTimer  = st_reg.capTsel ? timeBaseA : timeBaseB;
    cmpTimer  = st_reg.cmpTsel ? timeBaseB : timeBaseA;
    access    = psel & penable;
    rd16      = 16'h0000;
    st_next   = st_reg;
    st_next.capIrq = 1'b0;
    st_next.cmpIrq = 1'b0;
    st_next.wake   = 1'b0;
    // pin synchronisers; first stage feeds only the second
    st_next.capSync1 = capturePin;
    st_next.capSync2 = st_reg.capSync1;
    st_next.capPrev  = st_reg.capSync2;
    st_next.fltSync1 = faultPinA;
    st_next.fltSync2 = st_reg.fltSync1;
    st_next.fltPrev  = st_reg.fltSync2;
    // capture event selection
    st_next.capModePrev = st_reg.capMode;
    unique case (st_reg.capMode)
      icoc_pkg::CAP_EVERY: rawEvt = rise | fall;
      icoc_pkg::CAP_FALL:  rawEvt = fall;
      icoc_pkg::CAP_RISE:  rawEvt = rise;
      icoc_pkg::CAP_RISE4, icoc_pkg::CAP_RISE16: begin
        if (rise) begin
          if (st_reg.prescale == ((st_reg.capMode == icoc_pkg::CAP_RISE4) ?
                                  icoc_pkg::PRESCALE_4 : icoc_pkg::PRESCALE_16)) begin
            rawEvt           = 1'b1;
            st_next.prescale = 4'h0;
          end else begin
            st_next.prescale = st_reg.prescale + 4'h1;
          end
        end
      end
      icoc_pkg::CAP_INT_ONLY: rawEvt = rise;
      icoc_pkg::CAP_OFF0, icoc_pkg::CAP_OFF: rawEvt = 1'b0;
    endcase
    // a mode change restarts the edge prescaler and capture grouping
    if (st_reg.capMode != st_reg.capModePrev) begin
      rawEvt            = 1'b0;
      st_next.prescale  = 4'h0;
      st_next.capIntCnt = 2'h0;
    end
    // idle-stop in a storing mode also blocks the idle wake; mode 111 still wakes
    capEvt  = rawEvt & ~(st_reg.capIdle & cpuIdle & storeMode);
    capFull = (st_reg.count == (AW+1)'(DEPTH));
    capPush = capEvt & storeMode & ~capFull;
    capPop  = access & ~pwrite & (paddr == icoc_pkg::OFS_CAP_BUF) & (st_reg.count != '0);
    if (capEvt & (cpuSleep | cpuIdle)) begin
      st_next.wake = 1'b1;
    end
    if (capPush) begin
      st_next.fifo[st_reg.wrPtr] = capTimer;
      st_next.wrPtr              = st_reg.wrPtr + 1'b1;
    end
    if (capPop) begin
      st_next.rdPtr = st_reg.rdPtr + 1'b1;
    end
    st_next.count = st_reg.count + {{AW{1'b0}}, capPush} - {{AW{1'b0}}, capPop};
    // overflow clears once a word is read or the channel is shut; a new overflow wins
    if (capPop || st_reg.capMode == icoc_pkg::CAP_OFF || st_reg.capMode == icoc_pkg::CAP_OFF0) begin
      st_next.capOv = 1'b0;
    end
    if (capEvt & storeMode & capFull) begin
      st_next.capOv = 1'b1;
    end
    if (capPush) begin
      if (st_reg.capIntCnt == st_reg.capIci) begin
        st_next.capIrq    = 1'b1;
        st_next.capIntCnt = 2'h0;
      end else begin
        st_next.capIntCnt = st_reg.capIntCnt + 2'h1;
      end
    end
    if (capEvt & (st_reg.capMode == icoc_pkg::CAP_INT_ONLY)) begin
      st_next.capIrq = 1'b1;
    end
    // compare channel
    mPri     = (cmpTimer == st_reg.cmpPri);
    mSec     = (cmpTimer == st_reg.cmpSec);
    cmpHalt  = st_reg.cmpIdle & cpuIdle;
    st_next.cmpModePrev = st_reg.cmpMode;
    if (st_reg.cmpMode != st_reg.cmpModePrev) begin
      st_next.cmpDone = 1'b0;
      unique case (st_reg.cmpMode)
        icoc_pkg::CMP_FORCE_LO:               st_next.cmpOut = 1'b1;
        icoc_pkg::CMP_TOGGLE:                 st_next.cmpOut = st_reg.cmpOut;
        icoc_pkg::CMP_PWM, icoc_pkg::CMP_PWM_FLT: st_next.cmpOut = (st_reg.cmpPri != VAL0);
        default:                              st_next.cmpOut = 1'b0;
      endcase
    end else if (!cmpHalt) begin
      unique case (st_reg.cmpMode)
        icoc_pkg::CMP_OFF: st_next.cmpOut = st_reg.cmpOut;
        icoc_pkg::CMP_FORCE_HI: begin
          if (mPri && !st_reg.cmpDone) begin
            st_next.cmpOut  = 1'b1;
            st_next.cmpDone = 1'b1;
            st_next.cmpIrq  = 1'b1;
          end
        end
        icoc_pkg::CMP_FORCE_LO: begin
          if (mPri && !st_reg.cmpDone) begin
            st_next.cmpOut  = 1'b0;
            st_next.cmpDone = 1'b1;
            st_next.cmpIrq  = 1'b1;
          end
        end
        icoc_pkg::CMP_TOGGLE: begin
          if (mPri) begin
            st_next.cmpOut = ~st_reg.cmpOut;
            st_next.cmpIrq = 1'b1;
          end
        end
        icoc_pkg::CMP_SINGLE, icoc_pkg::CMP_CONT: begin
          if (st_reg.cmpOut && mSec) begin
            st_next.cmpOut  = 1'b0;
            st_next.cmpIrq  = 1'b1;
            st_next.cmpDone = (st_reg.cmpMode == icoc_pkg::CMP_SINGLE);
          end else if (!st_reg.cmpOut && mPri && !st_reg.cmpDone) begin
            st_next.cmpOut = 1'b1;
          end
        end
        icoc_pkg::CMP_PWM, icoc_pkg::CMP_PWM_FLT: begin
          // period assumed to restart at timer zero; duty is the primary value
          if (cmpTimer == VAL0) begin
            st_next.cmpOut = (st_reg.cmpPri != VAL0);
          end
          if (mPri) begin
            st_next.cmpOut = 1'b0;
          end
          if (st_reg.cmpMode == icoc_pkg::CMP_PWM_FLT) begin
            if (st_reg.cmpFlt && st_reg.fltSync2 && cmpTimer == VAL0) begin
              st_next.cmpFlt = 1'b0;
            end
            if (fFall) begin
              st_next.cmpFlt = 1'b1;
              st_next.cmpIrq = 1'b1;
            end
            if (st_next.cmpFlt) begin
              st_next.cmpOut = 1'b0;
            end
          end
        end
      endcase
    end
    st_next.pin = (st_reg.cmpMode == icoc_pkg::CMP_OFF) ? gpioPortOut : st_next.cmpOut;
    // apb writes; status bits are not writable
    if (access && pwrite) begin
      unique case (paddr)
        icoc_pkg::OFS_CAP_CTL: begin
          st_next.capIdle = pwdata[icoc_pkg::CAP_IDLE_BIT];
          st_next.capTsel = pwdata[icoc_pkg::CAP_TSEL_BIT];
          st_next.capIci  = pwdata[icoc_pkg::CAP_ICI_LSB +: 2];
          st_next.capMode = pwdata[icoc_pkg::MODE_LSB +: 3];
        end
        icoc_pkg::OFS_CMP_CTL: begin
          // timer should be stopped by software first, or one match may be lost
          st_next.cmpIdle = pwdata[icoc_pkg::CMP_IDLE_BIT];
          st_next.cmpTsel = pwdata[icoc_pkg::CMP_TSEL_BIT];
          st_next.cmpMode = pwdata[icoc_pkg::MODE_LSB +: 3];
        end
        icoc_pkg::OFS_CMP_PRI: st_next.cmpPri = pwdata[15:0];
        icoc_pkg::OFS_CMP_SEC: st_next.cmpSec = pwdata[15:0];
        default: begin
        end
      endcase
    end
    // read data prepared in the setup cycle
    if (psel && !penable) begin
      unique case (paddr)
        icoc_pkg::OFS_CAP_CTL: begin
          rd16[icoc_pkg::CAP_IDLE_BIT]      = st_reg.capIdle;
          rd16[icoc_pkg::CAP_TSEL_BIT]      = st_reg.capTsel;
          rd16[icoc_pkg::CAP_ICI_LSB +: 2]  = st_reg.capIci;
          rd16[icoc_pkg::CAP_OV_BIT]        = st_reg.capOv;
          rd16[icoc_pkg::CAP_BNE_BIT]       = (st_reg.count != '0);
          rd16[icoc_pkg::MODE_LSB +: 3]     = st_reg.capMode;
        end
        icoc_pkg::OFS_CAP_BUF: rd16 = st_reg.fifo[st_reg.rdPtr];
        icoc_pkg::OFS_CMP_CTL: begin
          rd16[icoc_pkg::CMP_IDLE_BIT]  = st_reg.cmpIdle;
          rd16[icoc_pkg::CMP_FLT_BIT]   = st_reg.cmpFlt;
          rd16[icoc_pkg::CMP_TSEL_BIT]  = st_reg.cmpTsel;
          rd16[icoc_pkg::MODE_LSB +: 3] = st_reg.cmpMode;
        end
        icoc_pkg::OFS_CMP_PRI: rd16 = st_reg.cmpPri;
        icoc_pkg::OFS_CMP_SEC: rd16 = st_reg.cmpSec;
        default:               rd16 = 16'h0000;
      endcase
      st_next.prdata = {16'h0000, rd16};
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata      = st_reg.prdata;
  assign pready      = 1'b1;
  assign pslverr     = psel & penable & ~addrMapped(paddr);
  assign comparePin  = st_reg.pin;
  assign captureIrq  = st_reg.capIrq;
  assign compareIrq  = st_reg.cmpIrq;
  assign wakeRequest = st_reg.wake;
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_ovf_set;
    capEvt && capFull && !capPop && st_reg.capMode != icoc_pkg::CAP_INT_ONLY |=> st_reg.capOv && st_reg.count == $past(st_reg.count);
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow not flagged or value stored");
  property p_depth;
    st_reg.count <= (AW+1)'(DEPTH);
  endproperty
  a_depth: assert property (p_depth) else $error("fifo count above depth");
  property p_push_value;
    capPush |=> st_reg.fifo[$past(st_reg.wrPtr)] == $past(st_reg.capTsel ? timeBaseA : timeBaseB);
  endproperty
  a_push_value: assert property (p_push_value) else $error("captured value differs from timer");
  property p_off_no_capture;
    st_reg.capMode == icoc_pkg::CAP_OFF |-> !capPush;
  endproperty
  a_off_no_capture: assert property (p_off_no_capture) else $error("capture while disabled");
  property p_irq_group;
    capPush && st_reg.capIntCnt == st_reg.capIci |=> captureIrq;
  endproperty
  a_irq_group: assert property (p_irq_group) else $error("capture interrupt missed");
  property p_force_hi;
    st_reg.cmpMode == icoc_pkg::CMP_FORCE_HI && st_reg.cmpModePrev == st_reg.cmpMode && mPri &&
      !st_reg.cmpDone && !cmpHalt |=> st_reg.cmpOut && compareIrq ##1 comparePin;
  endproperty
  a_force_hi: assert property (p_force_hi) else $error("mode 001 match did not drive high");
  property p_force_lo_entry;
    st_reg.cmpMode == icoc_pkg::CMP_FORCE_LO && st_reg.cmpModePrev != st_reg.cmpMode |=> st_reg.cmpOut;
  endproperty
  a_force_lo_entry: assert property (p_force_lo_entry) else $error("mode 010 did not start high");
  property p_pwm_quiet;
    st_reg.cmpMode == icoc_pkg::CMP_PWM && $past(st_reg.cmpMode) == icoc_pkg::CMP_PWM |-> !compareIrq;
  endproperty
  a_pwm_quiet: assert property (p_pwm_quiet) else $error("interrupt in pwm without fault");
  property p_flt_clear;
    $fell(st_reg.cmpFlt) |-> $past(st_reg.fltSync2) && $past(st_reg.cmpMode) == icoc_pkg::CMP_PWM_FLT;
  endproperty
  a_flt_clear: assert property (p_flt_clear) else $error("fault flag cleared without hardware cause");
  property p_gpio;
    st_reg.cmpMode == icoc_pkg::CMP_OFF |=> comparePin == $past(gpioPortOut);
  endproperty
  a_gpio: assert property (p_gpio) else $error("disabled pin not following port");
  property p_idle_hold;
    cmpHalt && st_reg.cmpModePrev == st_reg.cmpMode && !(psel && penable && pwrite) |=> $stable(st_reg.cmpOut);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("compare moved while halted in idle");
  c_overflow: cover property (capEvt && capFull);
  c_fault:    cover property (st_reg.cmpMode == icoc_pkg::CMP_PWM_FLT && compareIrq);
  c_pulse:    cover property (st_reg.cmpMode == icoc_pkg::CMP_CONT && compareIrq);
  c_wake:     cover property (wakeRequest);
endmodule

// ---- common/icoc_pkg.sv ----
// constants shared by the capture/compare block
package icoc_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFS_CAP_CTL = 8'h00;
  localparam logic [7:0]  OFS_CAP_BUF = 8'h04;
  localparam logic [7:0]  OFS_CMP_CTL = 8'h08;
  localparam logic [7:0]  OFS_CMP_PRI = 8'h0C;
  localparam logic [7:0]  OFS_CMP_SEC = 8'h10;
  localparam logic [15:0] CTL_RESET   = 16'h0000;
  localparam logic [15:0] VAL_RESET   = 16'h0000;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CAP_IDLE_BIT = 13;
  localparam int CAP_TSEL_BIT = 7;
  localparam int CAP_ICI_LSB  = 5;
  localparam int CAP_OV_BIT   = 4;
  localparam int CAP_BNE_BIT  = 3;
  localparam int CMP_IDLE_BIT = 13;
  localparam int CMP_FLT_BIT  = 4;
  localparam int CMP_TSEL_BIT = 3;
  localparam int MODE_LSB     = 0;
  // ----------------------------------------------------------------
  // capture modes
  // ----------------------------------------------------------------
  localparam logic [2:0] CAP_OFF0      = 3'h0;
  localparam logic [2:0] CAP_EVERY     = 3'h1;
  localparam logic [2:0] CAP_FALL      = 3'h2;
  localparam logic [2:0] CAP_RISE      = 3'h3;
  localparam logic [2:0] CAP_RISE4     = 3'h4;
  localparam logic [2:0] CAP_RISE16    = 3'h5;
  localparam logic [2:0] CAP_OFF       = 3'h6;
  localparam logic [2:0] CAP_INT_ONLY  = 3'h7;
  localparam logic [3:0] PRESCALE_4    = 4'h3;
  localparam logic [3:0] PRESCALE_16   = 4'hF;
  // ----------------------------------------------------------------
  // compare modes
  // ----------------------------------------------------------------
  localparam logic [2:0] CMP_OFF       = 3'h0;
  localparam logic [2:0] CMP_FORCE_HI  = 3'h1;
  localparam logic [2:0] CMP_FORCE_LO  = 3'h2;
  localparam logic [2:0] CMP_TOGGLE    = 3'h3;
  localparam logic [2:0] CMP_SINGLE    = 3'h4;
  localparam logic [2:0] CMP_CONT      = 3'h5;
  localparam logic [2:0] CMP_PWM       = 3'h6;
  localparam logic [2:0] CMP_PWM_FLT   = 3'h7;
endpackage

// ---- sim/icoc_pin_partner.sv ----
// pin-side partner: drives the capture input and the fault input
`timescale 1ns/10ps
module icoc_pin_partner (
  input  wire logic mclk,
  output logic      capturePin,
  output logic      faultPinA
);
  initial begin
    capturePin = 1'b0;
    faultPinA  = 1'b1;
  end
  // four cycles per level: the pin passes a two-flop synchroniser
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge mclk);
      capturePin <= 1'b1;
      repeat (4) @(posedge mclk);
      capturePin <= 1'b0;
      repeat (4) @(posedge mclk);
    end
  endtask
  // fault stays low afterwards, so the fault flag cannot clear
  task automatic fault();
    @(posedge mclk);
    faultPinA <= 1'b0;
  endtask
endmodule

// ---- sim/icoc_capture_compare_tb.sv ----
// self-checking bench for the capture/compare block
`timescale 1ns/10ps
module icoc_capture_compare_tb;
  logic        mclk        = 1'b0;
  logic        rst         = 1'b1;
  logic [7:0]  paddr       = 8'h00;
  logic        psel        = 1'b0;
  logic        penable     = 1'b0;
  logic        pwrite      = 1'b0;
  logic [31:0] pwdata      = 32'h0000_0000;
  logic [15:0] timeBaseA   = 16'h0000;
  logic [15:0] timeBaseB   = 16'hA5C3;
  logic        cpuIdle     = 1'b0;
  logic        cpuSleep    = 1'b0;
  logic        gpioPortOut = 1'b0;
  logic        holdA       = 1'b1;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        capturePin;
  logic        faultPinA;
  logic        comparePin;
  logic        captureIrq;
  logic        compareIrq;
  logic        wakeRequest;
  logic        lastErr;
  logic [31:0] rd;
  int          errors      = 0;
  int          comparisons = 0;
  int          capIrqs     = 0;
  int          cmpIrqs     = 0;
  int          wakes       = 0;
  int          base;
  int          wbase;

  always #25 mclk = ~mclk;
  // held timer reads as stopped while compare control is written
  always @(posedge mclk) begin
    timeBaseA <= holdA ? 16'h0000 : timeBaseA + 16'h0001;
    if (captureIrq === 1'b1) capIrqs <= capIrqs + 1;
    if (compareIrq === 1'b1) cmpIrqs <= cmpIrqs + 1;
    if (wakeRequest === 1'b1) wakes <= wakes + 1;
  end

  icoc_capture_compare #(.DEPTH(4)) icoc_capture_compare_inst (
    .mclk(mclk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timeBaseA(timeBaseA), .timeBaseB(timeBaseB),
    .cpuIdle(cpuIdle), .cpuSleep(cpuSleep), .capturePin(capturePin),
    .faultPinA(faultPinA), .gpioPortOut(gpioPortOut), .comparePin(comparePin),
    .captureIrq(captureIrq), .compareIrq(compareIrq), .wakeRequest(wakeRequest)
  );
  icoc_pin_partner icoc_pin_partner_inst (
    .mclk(mclk), .capturePin(capturePin), .faultPinA(faultPinA)
  );

  // ----------------------------------------------------------------
  // bus and comparison tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= {16'h0000, d};
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    apb(1'b0, a, 16'h0000);
    check(rd, {16'h0000, e});
  endtask
  task automatic print_verdict();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_reset();
    rchk(icoc_pkg::OFS_CAP_CTL, icoc_pkg::CTL_RESET);
    rchk(icoc_pkg::OFS_CMP_CTL, icoc_pkg::CTL_RESET);
    rchk(icoc_pkg::OFS_CMP_PRI, icoc_pkg::VAL_RESET);
    rchk(8'h40, 16'h0000);
    check(lastErr, 1'b1);
    check(pready, 1'b1);
    $display("test reset done");
  endtask
  task automatic test_capture();
    apb(1'b1, icoc_pkg::OFS_CAP_CTL, 16'h0003);
    icoc_pin_partner_inst.pulses(1);
    repeat (8) @(posedge mclk);
    rchk(icoc_pkg::OFS_CAP_CTL, 16'h000B);
    rchk(icoc_pkg::OFS_CAP_BUF, 16'hA5C3);
    rchk(icoc_pkg::OFS_CAP_CTL, 16'h0003);
    icoc_pin_partner_inst.pulses(5);
    repeat (8) @(posedge mclk);
    rchk(icoc_pkg::OFS_CAP_CTL, 16'h001B);
    apb(1'b1, icoc_pkg::OFS_CAP_CTL, 16'h0003);
    rchk(icoc_pkg::OFS_CAP_CTL, 16'h001B);
    repeat (4) rchk(icoc_pkg::OFS_CAP_BUF, 16'hA5C3);
    rchk(icoc_pkg::OFS_CAP_CTL, 16'h0003);
    apb(1'b1, icoc_pkg::OFS_CAP_CTL, 16'h0083);
    icoc_pin_partner_inst.pulses(1);
    repeat (8) @(posedge mclk);
    rchk(icoc_pkg::OFS_CAP_BUF, 16'h0000);
    $display("test capture done");
  endtask
  task automatic test_modes();
    logic [15:0] ctl[10] = '{16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0005,
                             16'h0006, 16'h0007, 16'h0023, 16'h0043, 16'h0063};
    int np[10] = '{2, 2, 2, 4, 16, 2, 2, 4, 4, 4};
    int ni[10] = '{4, 2, 2, 1, 1, 0, 2, 2, 1, 1};
    for (int i = 0; i < 10; i++) begin
      cpuIdle <= (i == 6);
      apb(1'b1, icoc_pkg::OFS_CAP_CTL, ctl[i]);
      base = capIrqs;
      wbase = wakes;
      icoc_pin_partner_inst.pulses(np[i]);
      repeat (8) @(posedge mclk);
      check(capIrqs - base, ni[i]);
      check(wakes - wbase, (i == 6) ? np[i] : 0);
      repeat (4) apb(1'b0, icoc_pkg::OFS_CAP_BUF, 16'h0000);
    end
    cpuIdle <= 1'b0;
    $display("test modes done");
  endtask
  task automatic test_compare();
    logic [15:0] cm[8]  = '{16'h0009, 16'h0001, 16'h0002, 16'h0004, 16'h0005, 16'h0006, 16'h0003, 16'h2003};
    logic        mid[8] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    logic        fin[8] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
    int          ir[8]  = '{0, 1, 1, 1, 1, 0, 1, 0};
    gpioPortOut <= 1'b1;
    apb(1'b1, icoc_pkg::OFS_CMP_PRI, 16'h0010);
    apb(1'b1, icoc_pkg::OFS_CMP_SEC, 16'h0020);
    repeat (3) @(posedge mclk);
    check(comparePin, 1'b1);
    for (int i = 0; i < 8; i++) begin
      holdA <= 1'b1;
      cpuIdle <= (i == 7);
      @(posedge mclk);
      apb(1'b1, icoc_pkg::OFS_CMP_CTL, cm[i]);
      base = cmpIrqs;
      holdA <= 1'b0;
      repeat (25) @(posedge mclk);
      check(comparePin, mid[i]);
      repeat (35) @(posedge mclk);
      check(comparePin, fin[i]);
      check(cmpIrqs - base, ir[i]);
    end
    cpuIdle <= 1'b0;
    apb(1'b1, icoc_pkg::OFS_CMP_CTL, 16'h0007);
    base = cmpIrqs;
    icoc_pin_partner_inst.fault();
    repeat (10) @(posedge mclk);
    check(cmpIrqs - base, 1);
    check(comparePin, 1'b0);
    rchk(icoc_pkg::OFS_CMP_CTL, 16'h0017);
    apb(1'b1, icoc_pkg::OFS_CMP_CTL, 16'h0007);
    rchk(icoc_pkg::OFS_CMP_CTL, 16'h0017);
    $display("test compare done");
  endtask

  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    test_reset();
    test_capture();
    test_modes();
    test_compare();
    print_verdict();
  end
  initial begin
    #2000000;
    errors++;
    print_verdict();
  end
endmodule
